// [verilog/shws_device.sv]
// Sensor end: serial slave, header decode, paced ready line, write buffer
`timescale 1ns/1ps
`default_nettype none
// What this link does
// - Host starts bytes only while ready high
// - Ready drops soon after each byte
// - Host waits 100 us, then ready high
// - Ready returns within 20 ms write, 1 ms read
// - Limits grow 5 ms slow, 11 ms debug
// - Low pulse at least 1 us; 80 ms boot
// - Host clocks null bytes for responses
// - Over 20 ms gap drops the sequence
// - Wake edge, 1.5 ms discarding bytes
// - Host wakes device by a select pulse
// - Checksum appended to every read response
// - Header: address, direction flag, count top bit
// - Nine bit count across bytes two, three
// - Write ends itself after counted bytes
// - Write address increments per data byte
// - Output bytes during writes are undefined
// - Host writes stay within configuration space
// - Clock idles high, sample rising, shift falling
// - Select frames bytes; output floats when high
// - Ready is open drain with pull-up
// - Sixteen bit checksum, low byte first
module shws_device #(
	parameter int unsigned BOOT_LOW_CYC = shws_pkg::BOOT_LOW_CYC,
	parameter int unsigned TIMEOUT_CYC  = shws_pkg::TIMEOUT_CYC,
	parameter int unsigned WR_RET_CYC   = shws_pkg::WR_RET_CYC,
	parameter int unsigned RD_RET_CYC   = shws_pkg::RD_RET_CYC,
	parameter int unsigned LOWF_ADD_CYC = shws_pkg::LOWF_ADD_CYC,
	parameter int unsigned DBG_ADD_CYC  = shws_pkg::DBG_ADD_CYC,
	parameter int unsigned WAKE_CYC     = shws_pkg::WAKE_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	shws_if.device                           link,
	input  wire logic                        sleep_req,
	input  wire logic                        low_freq,
	input  wire logic                        debug_en,
	output logic                             wr_valid,
	input  wire logic                        wr_ready,
	output logic [shws_pkg::ADDR_W-1:0]      wr_addr,
	output logic [7:0]                       wr_data,
	output logic [shws_pkg::ADDR_W-1:0]      rd_addr,
	input  wire logic [7:0]                  rd_data,
	output logic                             asleep,
	output logic                             late_drop
);
	localparam int TW = shws_pkg::TMR_W;
	localparam int AW = shws_pkg::ADDR_W;
	localparam int CW = shws_pkg::CNT_W;
	localparam int DEPTH = shws_pkg::FIFO_DEPTH;
	localparam int PW = $clog2(DEPTH);
	localparam int NW = $clog2(DEPTH + 1);
	localparam int SCK = shws_pkg::PIN_SCK;
	localparam int SS = shws_pkg::PIN_SS;
	localparam int MOSI = shws_pkg::PIN_MOSI;
	localparam int WAKE = shws_pkg::PIN_WAKE;

	logic [3:0]          pin_raw;
	logic [2:0]          sync_q [4];
	logic                filt_q [4];
	logic                prev_q [4];
	logic                sck_rise, sck_fall, ss_fall, wake_rise;
	logic [2:0]          bit_q;
	logic [7:0]          rx_q, tx_sh_q, tx_byte_q, rx_byte;
	logic                miso_q;
	logic                byte_done, byte_ok, discard;
	shws_pkg::shws_seq_t seq_q;
	logic [AW-1:0]       addr_q;
	logic [CW-1:0]       cnt_q, cnt_n;
	logic                rd_q, fetch_q;
	logic [15:0]         crc_q, crc_n;
	logic [TW-1:0]       idle_q, wake_q, low_q, ret_lim;
	logic                asleep_q, waking_q, boot_q, busy_q, kind_wr_q;
	logic [AW+7:0]       mem_q [DEPTH];
	logic [PW-1:0]       wp_q, rp_q;
	logic [NW-1:0]       fill_q;
	logic                full, push, pop, drop, timeout, min_done;

	assign pin_raw = {link.wake_sense, link.mosi, link.ss_n, link.sck};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					sync_q[gi] <= {3{shws_pkg::PIN_IDLE[gi]}};
					filt_q[gi] <= shws_pkg::PIN_IDLE[gi];
					prev_q[gi] <= shws_pkg::PIN_IDLE[gi];
				end else if (clk_en) begin
					sync_q[gi] <= {sync_q[gi][1:0], pin_raw[gi]};
					if (sync_q[gi][1] == sync_q[gi][2]) begin
						filt_q[gi] <= sync_q[gi][2];
					end
					prev_q[gi] <= filt_q[gi];
				end
			end
		end
	endgenerate

	assign sck_rise = filt_q[SCK] & ~prev_q[SCK];
	assign sck_fall = ~filt_q[SCK] & prev_q[SCK];
	assign ss_fall = ~filt_q[SS] & prev_q[SS];
	assign wake_rise = filt_q[WAKE] & ~prev_q[WAKE];
	assign rx_byte = {rx_q[6:0], filt_q[MOSI]};
	assign byte_done = sck_rise & ~filt_q[SS] & (bit_q == 3'h7);
	// Bytes during boot or wake-up may be mistimed, so they never reach decode
	assign discard = asleep_q | waking_q | boot_q;
	assign byte_ok = byte_done & ~discard;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_q <= 3'h0;
			rx_q <= 8'h00;
			tx_sh_q <= 8'h00;
			miso_q <= 1'b1;
		end else if (clk_en) begin
			if (ss_fall) begin
				bit_q <= 3'h0;
				tx_sh_q <= tx_byte_q;
			end else if (!filt_q[SS]) begin
				if (sck_fall) begin
					miso_q <= tx_sh_q[7];
					tx_sh_q <= {tx_sh_q[6:0], 1'b0};
				end
				if (sck_rise) begin
					rx_q <= rx_byte;
					bit_q <= bit_q + 3'h1;
				end
			end
		end
	end

	assign link.miso = miso_q;
	assign link.miso_oe = ~filt_q[SS];

	assign crc_n = shws_pkg::shws_crc_step(
		(seq_q == shws_pkg::SEQ_ADDR) ? shws_pkg::CRC_INIT : crc_q, rx_byte);
	assign cnt_n = {cnt_q[CW-1], rx_byte};
	assign timeout = (seq_q != shws_pkg::SEQ_ADDR)
		&& (idle_q == TW'(TIMEOUT_CYC - 1));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_q <= '0;
		end else if (clk_en) begin
			if (byte_done || seq_q == shws_pkg::SEQ_ADDR) begin
				idle_q <= '0;
			end else begin
				idle_q <= idle_q + TW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seq_q <= shws_pkg::SEQ_ADDR;
			addr_q <= '0;
			cnt_q <= '0;
			rd_q <= 1'b0;
			fetch_q <= 1'b0;
			crc_q <= shws_pkg::CRC_INIT;
			tx_byte_q <= shws_pkg::NULL_BYTE;
		end else if (clk_en) begin
			if (fetch_q) begin
				tx_byte_q <= rd_data;
				crc_q <= shws_pkg::shws_crc_step(crc_q, rd_data);
				fetch_q <= 1'b0;
			end
			if (timeout) begin
				seq_q <= shws_pkg::SEQ_ADDR;
			end else if (byte_ok) begin
				case (seq_q)
				shws_pkg::SEQ_ADDR: begin
					addr_q[7:0] <= rx_byte;
					crc_q <= crc_n;
					seq_q <= shws_pkg::SEQ_HDR2;
				end
				shws_pkg::SEQ_HDR2: begin
					rd_q <= rx_byte[7];
					cnt_q[CW-1] <= rx_byte[6];
					addr_q[AW-1:8] <= rx_byte[2:0];
					crc_q <= crc_n;
					seq_q <= shws_pkg::SEQ_CNT;
				end
				shws_pkg::SEQ_CNT: begin
					cnt_q <= cnt_n;
					crc_q <= crc_n;
					if (cnt_n == '0 && rd_q) begin
						tx_byte_q <= crc_n[7:0];
						seq_q <= shws_pkg::SEQ_CRC_LO;
					end else if (cnt_n == '0) begin
						seq_q <= shws_pkg::SEQ_ADDR;
					end else if (rd_q) begin
						fetch_q <= 1'b1;
						seq_q <= shws_pkg::SEQ_RDATA;
					end else begin
						tx_byte_q <= shws_pkg::NULL_BYTE;
						seq_q <= shws_pkg::SEQ_WDATA;
					end
				end
				shws_pkg::SEQ_WDATA: begin
					addr_q <= addr_q + AW'(1);
					cnt_q <= cnt_q - CW'(1);
					if (cnt_q == CW'(1)) begin
						seq_q <= shws_pkg::SEQ_ADDR;
					end
				end
				shws_pkg::SEQ_RDATA: begin
					addr_q <= addr_q + AW'(1);
					cnt_q <= cnt_q - CW'(1);
					if (cnt_q == CW'(1)) begin
						tx_byte_q <= crc_q[7:0];
						seq_q <= shws_pkg::SEQ_CRC_LO;
					end else begin
						fetch_q <= 1'b1;
					end
				end
				shws_pkg::SEQ_CRC_LO: begin
					tx_byte_q <= crc_q[15:8];
					seq_q <= shws_pkg::SEQ_CRC_HI;
				end
				default: begin
					seq_q <= shws_pkg::SEQ_ADDR;
				end
				endcase
			end
		end
	end

	assign rd_addr = addr_q;

	// Two-entry write buffer: a stalled consumer holds ready low until the limit, then loses its oldest word
	assign full = fill_q == NW'(DEPTH);
	assign push = byte_ok && seq_q == shws_pkg::SEQ_WDATA && !full;
	assign pop = (fill_q != '0) && (wr_ready || drop);
	assign wr_valid = fill_q != '0;
	assign wr_addr = mem_q[rp_q][AW+7:8];
	assign wr_data = mem_q[rp_q][7:0];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_q <= '0;
			rp_q <= '0;
			fill_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (clk_en) begin
			if (push) begin
				mem_q[wp_q] <= {addr_q, rx_byte};
				wp_q <= wp_q + PW'(1);
			end
			if (pop) begin
				rp_q <= rp_q + PW'(1);
			end
			fill_q <= fill_q + NW'(push) - NW'(pop);
		end
	end

	assign ret_lim = TW'(kind_wr_q ? WR_RET_CYC : RD_RET_CYC)
		+ (low_freq ? TW'(LOWF_ADD_CYC) : TW'(0))
		+ (debug_en ? TW'(DBG_ADD_CYC) : TW'(0));
	assign min_done = low_q >= TW'(shws_pkg::MIN_LOW_CYC - 1);
	// A consumer stuck past the limit loses its oldest word, not the link
	assign drop = busy_q && full && low_q == ret_lim - TW'(1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			boot_q <= 1'b1;
			busy_q <= 1'b0;
			kind_wr_q <= 1'b0;
			low_q <= '0;
			late_drop <= 1'b0;
		end else if (clk_en) begin
			late_drop <= drop;
			if (boot_q) begin
				low_q <= low_q + TW'(1);
				if (low_q == TW'(BOOT_LOW_CYC - 1)) begin
					boot_q <= 1'b0;
					low_q <= '0;
				end
			end else if (byte_done) begin
				busy_q <= 1'b1;
				low_q <= '0;
				kind_wr_q <= seq_q == shws_pkg::SEQ_WDATA;
			end else if (busy_q) begin
				low_q <= low_q + TW'(1);
				if (min_done && !full && !fetch_q) begin
					busy_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			asleep_q <= 1'b0;
			waking_q <= 1'b0;
			wake_q <= '0;
		end else if (clk_en) begin
			if (asleep_q && wake_rise) begin
				asleep_q <= 1'b0;
				waking_q <= 1'b1;
				wake_q <= '0;
			end else if (waking_q) begin
				wake_q <= wake_q + TW'(1);
				if (wake_q == TW'(WAKE_CYC - 1)) begin
					waking_q <= 1'b0;
				end
			end else if (sleep_req && !busy_q && !boot_q
				&& seq_q == shws_pkg::SEQ_ADDR) begin
				asleep_q <= 1'b1;
			end
		end
	end

	assign asleep = asleep_q;
	assign link.ready_oe = boot_q | busy_q | asleep_q | waking_q;
endmodule : shws_device
`default_nettype wire

// [inc/shws_pkg.sv]
// Constants, state types and checksum step shared by both link ends
`default_nettype none
package shws_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int TMR_W = 24;
	localparam int ADDR_W = 11;
	localparam int CNT_W = 9;
	localparam int REM_W = 10;
	localparam int FIFO_DEPTH = 2;
	localparam int MIN_LOW_US = 1;
	localparam int MIN_LOW_CYC = MIN_LOW_US * CLK_MHZ;
	localparam int BOOT_LOW_MS = 80;
	localparam int BOOT_LOW_CYC = BOOT_LOW_MS * CLK_MHZ * 1000;
	localparam int TIMEOUT_MS = 20;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int WR_RET_MS = 20;
	localparam int WR_RET_CYC = WR_RET_MS * CLK_MHZ * 1000;
	localparam int RD_RET_MS = 1;
	localparam int RD_RET_CYC = RD_RET_MS * CLK_MHZ * 1000;
	localparam int LOWF_ADD_MS = 5;
	localparam int LOWF_ADD_CYC = LOWF_ADD_MS * CLK_MHZ * 1000;
	localparam int DBG_ADD_MS = 11;
	localparam int DBG_ADD_CYC = DBG_ADD_MS * CLK_MHZ * 1000;
	localparam int WAKE_US = 1500;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
	localparam int GAP_US = 100;
	localparam int GAP_CYC = GAP_US * CLK_MHZ;
	localparam int SPI_MAX_HZ = 4_000_000;
	localparam int SCK_HALF_CYC = (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
	localparam int STEP_END = 16;
	localparam int RD_TAIL = 2;
	localparam logic [ADDR_W-1:0] LAST_CFG_ADDR = 11'h4DF;
	localparam logic [7:0] NULL_BYTE = 8'h00;
	localparam logic [2:0] HDR2_UNDEF = 3'h0;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// Pin order: sck, ss_n, mosi, wake
	localparam int PIN_SCK = 0;
	localparam int PIN_SS = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_WAKE = 3;
	localparam logic [3:0] PIN_IDLE = 4'h3;
	typedef enum logic [2:0] {
		SEQ_ADDR = 3'b000, SEQ_HDR2 = 3'b001, SEQ_CNT = 3'b010,
		SEQ_WDATA = 3'b011, SEQ_RDATA = 3'b100, SEQ_CRC_LO = 3'b101,
		SEQ_CRC_HI = 3'b110
	} shws_seq_t;
	typedef enum logic [1:0] {
		HST_IDLE = 2'b00, HST_WAIT = 2'b01, HST_SHIFT = 2'b10,
		HST_WAKE = 2'b11
	} shws_hst_t;
	function automatic logic [15:0] shws_crc_step(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : shws_crc_step
endpackage : shws_pkg
`default_nettype wire

// [inc/shws_if.sv]
// Link pins between the host master and the sensor's serial port
`timescale 1ns/1ps
`default_nettype none
interface shws_if;
	logic sck;
	logic mosi;
	logic ss_n;
	logic miso;
	logic miso_oe;
	logic ready_oe;
	logic ready_level;
	logic miso_line;
	logic wake_sense;
	// Pull-ups: ready idles high, a floating data line reads high
	assign ready_level = ~ready_oe;
	assign miso_line = miso_oe ? miso : 1'b1;
	// Select low turns on the wake transistor, a rising edge at wake
	assign wake_sense = ~ss_n;
	modport host (output sck, mosi, ss_n, input miso_line, ready_level);
	modport device (input sck, mosi, ss_n, wake_sense,
		output miso, miso_oe, ready_oe);
endinterface : shws_if
`default_nettype wire

// [verilog/shws_host.sv]
// Host end: paced master that issues read and write sequences
`timescale 1ns/1ps
`default_nettype none
module shws_host #(
	parameter int unsigned GAP_CYC = shws_pkg::GAP_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	shws_if.host                             link,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic                        cmd_read,
	input  wire logic [shws_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [shws_pkg::CNT_W-1:0]  cmd_count,
	output logic                             cmd_reject,
	input  wire logic                        wake_req,
	input  wire logic                        wdat_valid,
	output logic                             wdat_ready,
	input  wire logic [7:0]                  wdat_data,
	output logic                             rdat_valid,
	output logic [7:0]                       rdat_data,
	output logic                             crc_good,
	output logic                             crc_bad,
	output logic                             busy
);
	localparam int TW = shws_pkg::TMR_W;
	localparam int AW = shws_pkg::ADDR_W;
	localparam int CW = shws_pkg::CNT_W;
	localparam int RW = shws_pkg::REM_W;

	shws_pkg::shws_hst_t st_q;
	logic [2:0]    rdy_s_q;
	logic          rdy_q, half_tick, start, end_ev, gap_done;
	logic [TW-1:0] gap_q, half_q;
	logic [4:0]    step_q;
	logic [1:0]    hidx_q;
	logic [RW-1:0] rem_q;
	logic [AW-1:0] addr_q;
	logic [CW-1:0] cnt_q;
	logic          rd_q, sck_q, ss_q, mosi_q;
	logic [7:0]    tx_q, rx_q, next_byte, crc_lo_q;
	logic [15:0]   crc_q;
	logic [AW:0]   last_addr;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdy_s_q <= 3'h0;
			rdy_q <= 1'b0;
		end else if (clk_en) begin
			rdy_s_q <= {rdy_s_q[1:0], link.ready_level};
			if (rdy_s_q[1] == rdy_s_q[2]) begin
				rdy_q <= rdy_s_q[2];
			end
		end
	end

	assign half_tick = half_q == TW'(shws_pkg::SCK_HALF_CYC - 1);
	assign end_ev = half_tick && ((st_q == shws_pkg::HST_SHIFT
		&& step_q == 5'(shws_pkg::STEP_END)) || st_q == shws_pkg::HST_WAKE);
	assign gap_done = gap_q == TW'(GAP_CYC - 1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gap_q <= '0;
		end else if (clk_en) begin
			if (end_ev) begin
				gap_q <= '0;
			end else if (!gap_done) begin
				gap_q <= gap_q + TW'(1);
			end
		end
	end

	always_comb begin
		case (hidx_q)
		2'h0: next_byte = addr_q[7:0];
		2'h1: next_byte = {rd_q, cnt_q[CW-1], shws_pkg::HDR2_UNDEF,
			addr_q[AW-1:8]};
		2'h2: next_byte = cnt_q[7:0];
		default: next_byte = rd_q ? shws_pkg::NULL_BYTE : wdat_data;
		endcase
	end

	// Waiting out the gap and then for ready high keeps each byte paced
	assign start = st_q == shws_pkg::HST_WAIT && gap_done && rdy_q
		&& (hidx_q != 2'h3 || rd_q || wdat_valid);
	assign wdat_ready = start && hidx_q == 2'h3 && !rd_q;
	assign cmd_ready = st_q == shws_pkg::HST_IDLE;
	assign busy = st_q != shws_pkg::HST_IDLE;
	assign last_addr = {1'b0, cmd_addr} + (AW + 1)'(cmd_count) - (AW + 1)'(1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= shws_pkg::HST_IDLE;
			half_q <= '0;
			step_q <= 5'h00;
			hidx_q <= 2'h0;
			rem_q <= '0;
			addr_q <= '0;
			cnt_q <= '0;
			rd_q <= 1'b0;
			sck_q <= 1'b1;
			ss_q <= 1'b1;
			mosi_q <= 1'b0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			crc_q <= shws_pkg::CRC_INIT;
			crc_lo_q <= 8'h00;
			cmd_reject <= 1'b0;
			rdat_valid <= 1'b0;
			rdat_data <= 8'h00;
			crc_good <= 1'b0;
			crc_bad <= 1'b0;
		end else if (clk_en) begin
			cmd_reject <= 1'b0;
			rdat_valid <= 1'b0;
			crc_good <= 1'b0;
			crc_bad <= 1'b0;
			half_q <= half_tick ? '0 : half_q + TW'(1);
			case (st_q)
			shws_pkg::HST_IDLE: begin
				half_q <= '0;
				if (wake_req) begin
					ss_q <= 1'b0;
					st_q <= shws_pkg::HST_WAKE;
				end else if (cmd_valid && !cmd_read && cmd_count != '0
					&& last_addr > {1'b0, shws_pkg::LAST_CFG_ADDR}) begin
					cmd_reject <= 1'b1;
				end else if (cmd_valid) begin
					rd_q <= cmd_read;
					addr_q <= cmd_addr;
					cnt_q <= cmd_count;
					rem_q <= cmd_read ? RW'(cmd_count) + RW'(shws_pkg::RD_TAIL)
						: RW'(cmd_count);
					hidx_q <= 2'h0;
					crc_q <= shws_pkg::CRC_INIT;
					st_q <= shws_pkg::HST_WAIT;
				end
			end
			shws_pkg::HST_WAIT: begin
				half_q <= '0;
				if (start) begin
					tx_q <= next_byte;
					ss_q <= 1'b0;
					step_q <= 5'h00;
					if (hidx_q != 2'h3) begin
						crc_q <= shws_pkg::shws_crc_step(crc_q, next_byte);
					end
					st_q <= shws_pkg::HST_SHIFT;
				end
			end
			shws_pkg::HST_SHIFT: begin
				if (half_tick && step_q == 5'(shws_pkg::STEP_END)) begin
					ss_q <= 1'b1;
					if (hidx_q != 2'h3) begin
						hidx_q <= hidx_q + 2'h1;
						st_q <= (hidx_q == 2'h2 && rem_q == '0)
							? shws_pkg::HST_IDLE : shws_pkg::HST_WAIT;
					end else begin
						rem_q <= rem_q - RW'(1);
						st_q <= (rem_q == RW'(1))
							? shws_pkg::HST_IDLE : shws_pkg::HST_WAIT;
						if (rd_q && rem_q > RW'(shws_pkg::RD_TAIL)) begin
							rdat_valid <= 1'b1;
							rdat_data <= rx_q;
							crc_q <= shws_pkg::shws_crc_step(crc_q, rx_q);
						end else if (rd_q && rem_q == RW'(shws_pkg::RD_TAIL)) begin
							crc_lo_q <= rx_q;
						end else if (rd_q) begin
							crc_good <= {rx_q, crc_lo_q} == crc_q;
							crc_bad <= {rx_q, crc_lo_q} != crc_q;
						end
						// Bytes returned during a write are never looked at
					end
				end else if (half_tick) begin
					step_q <= step_q + 5'h01;
					if (!step_q[0]) begin
						sck_q <= 1'b0;
						mosi_q <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end else begin
						sck_q <= 1'b1;
						rx_q <= {rx_q[6:0], link.miso_line};
					end
				end
			end
			default: begin
				if (half_tick) begin
					ss_q <= 1'b1;
					st_q <= shws_pkg::HST_IDLE;
				end
			end
			endcase
		end
	end

	assign link.sck = sck_q;
	assign link.ss_n = ss_q;
	assign link.mosi = mosi_q;
endmodule : shws_host
`default_nettype wire

// [tb/shws_asserts.sv]
// Pin checker for the link: framing, clock phase and ready pacing
`timescale 1ns/1ps
`default_nettype none
module shws_asserts #(
	parameter int BOOT = 2000,
	parameter int GAP  = 400
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic ready_oe
);
	localparam int MIN_LOW = shws_pkg::MIN_LOW_CYC;
	logic       sck_q;
	logic [3:0] bit_q;
	int         low_q;
	int         hi_q;
	int         up_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sck_q <= 1'b1;
		else
			sck_q <= sck;
	end
	// Rises seen inside the current frame; select high clears it
	always_ff @(posedge clk or posedge reset) begin
		if (reset || ss_n)
			bit_q <= 4'h0;
		else if (sck && !sck_q)
			bit_q <= bit_q + 4'h1;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset || !ready_oe)
			low_q <= 0;
		else
			low_q <= low_q + 1;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset || !ss_n)
			hi_q <= 0;
		else
			hi_q <= hi_q + 1;
	end
	// Saturates so the counter never wraps on long runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			up_q <= 0;
		else if (up_q < BOOT)
			up_q <= up_q + 1;
	end
	a_start_when_ready: assert property (
		($fell(sck) && bit_q == 4'h0) |-> !ready_oe)
		else $error("byte started while ready low");
	a_ready_drop: assert property (
		(sck && !sck_q && !ss_n && bit_q == 4'h7) |-> ##[1:10] ready_oe)
		else $error("ready not pulled low after byte");
	a_gap_kept: assert property ($fell(ss_n) |-> hi_q >= GAP - 2)
		else $error("byte gap too short");
	a_low_pulse_min: assert property ($fell(ready_oe) |-> low_q >= MIN_LOW)
		else $error("ready low pulse too short");
	a_boot_low: assert property ((up_q < BOOT - 1) |-> ready_oe)
		else $error("ready released during boot");
	a_clock_idle: assert property (ss_n |-> sck)
		else $error("clock low outside frame");
	a_mosi_stable: assert property ($rose(sck) |-> $stable(mosi))
		else $error("host data moved at sampling edge");
	a_miso_stable: assert property (
		($rose(sck) && miso_oe && $past(miso_oe)) |-> $stable(miso))
		else $error("device data moved at sampling edge");
	a_miso_float: assert property (ss_n [*6] |-> !miso_oe)
		else $error("data out driven while deselected");
	c_byte: cover property (bit_q == 4'h8 && $rose(ss_n));
	c_wake: cover property (bit_q == 4'h0 && $rose(ss_n));
	c_ready_back: cover property ($fell(ready_oe));
endmodule : shws_asserts
`default_nettype wire

// [tb/testbench.sv]
// Host and sensor ends joined: sequence table, then edge cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {
		logic       rd;
		logic [10:0] a;
		logic [8:0] n;
		logic [8:0] w;
		logic       rej;
	} shws_row_t;
	// Shortened pacing keeps the run short; checker defaults match these
	localparam int T_BOOT = 2000, T_TMO = 3000, T_WR = 1500, T_GAP = 400;
	localparam int T_LOWF = 100, T_DBG = 200, T_WAKE = 300;
	localparam int LIM = T_WR + T_LOWF + T_DBG;
	shws_row_t   rows [6];
	logic        clk = 1'b0, reset = 1'b1, hen = 1'b1, mon = 1'b1, den = 1'b1;
	logic        cmd_valid = 1'b0, cmd_read = 1'b0, wake_req = 1'b0;
	logic [10:0] cmd_addr = 11'h000, base = 11'h000, wr_addr, rd_addr;
	logic [8:0]  cmd_count = 9'h000;
	logic        wdat_valid = 1'b1, sleep_req = 1'b0, wr_ready = 1'b1;
	logic        low_freq = 1'b0, debug_en = 1'b0, sck_q = 1'b1, ss_q = 1'b1;
	logic        cmd_ready, cmd_reject, wdat_ready, rdat_valid, crc_good;
	logic        crc_bad, busy, wr_valid, asleep, late_drop;
	logic [7:0]  wdat_data, rdat_data, wr_data, rd_data, sh;
	logic [7:0]  mem [2048];
	logic [7:0]  hb [4];
	int          num_errors = 0, comparisons = 0, cyc = 0, wi = 0;
	int          wc, rc, gc, bc, rj, ld, nb, lowc, dl;
	shws_if lk ();
	shws_host #(.GAP_CYC(T_GAP)) u_shws_host (.clk, .reset, .clk_en(hen),
		.link(lk), .cmd_valid, .cmd_ready, .cmd_read, .cmd_addr, .cmd_count,
		.cmd_reject, .wake_req, .wdat_valid, .wdat_ready, .wdat_data,
		.rdat_valid, .rdat_data, .crc_good, .crc_bad, .busy);
	shws_device #(.BOOT_LOW_CYC(T_BOOT), .TIMEOUT_CYC(T_TMO),
		.WR_RET_CYC(T_WR), .LOWF_ADD_CYC(T_LOWF), .DBG_ADD_CYC(T_DBG),
		.WAKE_CYC(T_WAKE)) u_shws_device (.clk, .reset, .clk_en(den),
		.link(lk), .sleep_req, .low_freq, .debug_en, .wr_valid, .wr_ready,
		.wr_addr, .wr_data, .rd_addr, .rd_data, .asleep, .late_drop);
	shws_asserts u_shws_asserts (.clk, .reset,
		.sck(lk.sck), .mosi(lk.mosi), .ss_n(lk.ss_n), .miso(lk.miso),
		.miso_oe(lk.miso_oe), .ready_oe(lk.ready_oe));
	assign rd_data = mem[rd_addr];
	always #4 clk = ~clk;
	task automatic chk_val(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	always @(negedge clk) wdat_data <= 8'(base + 11'(wi)) ^ 8'hC3;
	// Samples settled values; expected bytes come from address, not pins
	always @(posedge clk) begin
		cyc++;
		if (!lk.ss_n && lk.sck && !sck_q)
			sh = {sh[6:0], lk.mosi};
		if (lk.ss_n && !ss_q && nb < 4) begin
			hb[nb] = sh;
			nb++;
		end
		sck_q = lk.sck;
		ss_q = lk.ss_n;
		if (wdat_valid && wdat_ready)
			wi++;
		if (rdat_valid) begin
			chk_val("rdat", 16'(mem[base + 11'(rc)]), 16'(rdat_data));
			rc++;
		end
		if (wr_valid && wr_ready) begin
			if (mon)
				chk_val("wr_addr", 16'(base + 11'(wc)), 16'(wr_addr));
			if (mon)
				chk_val("wr_data", 16'(8'(base + 11'(wc)) ^ 8'hC3),
					16'(wr_data));
			mem[base + 11'(wc)] = 8'(base + 11'(wc)) ^ 8'hC3;
			wc++;
		end
		lowc = lk.ready_level ? 0 : lowc + 1;
		if (late_drop && ld == 0)
			dl = lowc;
		gc += int'(crc_good);
		bc += int'(crc_bad);
		rj += int'(cmd_reject);
		ld += int'(late_drop);
		if (cyc == 90000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic run(input shws_row_t r);
		base = r.a;
		{wc, rc, gc, bc, rj, ld, wi, nb, dl} = '0;
		@(negedge clk);
		{cmd_read, cmd_addr, cmd_count, cmd_valid} = {r.rd, r.a, r.n, 1'b1};
		@(posedge clk);
		while (cmd_ready !== 1'b1)
			@(posedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		while (busy !== 1'b0)
			@(negedge clk);
		repeat (20) @(negedge clk);
		chk_val("writes", 16'(r.w), 16'(wc));
		chk_val("reads", r.rd ? 16'(r.n) : 16'h0000, 16'(rc));
		chk_val("crc_good", 16'(r.rd), 16'(gc));
		chk_val("crc_bad", 16'h0000, 16'(bc));
		chk_val("reject", 16'(r.rej), 16'(rj));
		if (!r.rej) begin
			chk_val("hdr1", 16'(r.a[7:0]), 16'(hb[0]));
			chk_val("hdr2", 16'({r.rd, r.n[8], 3'h0, r.a[10:8]}), 16'(hb[1]));
			chk_val("hdr3", 16'(r.n[7:0]), 16'(hb[2]));
		end
		if (r.rd && r.n != 9'h000)
			chk_val("null_byte", 16'h0000, 16'(hb[3]));
		$display("test rd=%0d addr %h count %h done", r.rd, r.a, r.n);
	endtask : run
	initial begin
		for (int i = 0; i < 2048; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		rows[0] = '{1'b0, 11'h4DE, 9'h002, 9'h002, 1'b0};
		rows[1] = '{1'b1, 11'h4DE, 9'h002, 9'h000, 1'b0};
		rows[2] = '{1'b1, 11'h000, 9'h000, 9'h000, 1'b0};
		rows[3] = '{1'b0, 11'h0FF, 9'h003, 9'h003, 1'b0};
		rows[4] = '{1'b1, 11'h0FE, 9'h003, 9'h000, 1'b0};
		rows[5] = '{1'b0, 11'h400, 9'h100, 9'h000, 1'b1};
		repeat (2) @(negedge clk);
		chk_val("rst_ready", 16'h0000, 16'(lk.ready_level));
		chk_val("rst_miso", 16'h0001, 16'(lk.miso_line));
		repeat (18) @(negedge clk);
		reset = 1'b0;
		$display("test reset done");
		for (int i = 0; i < 6; i++)
			run(rows[i]);
		// Stalled sink: the first full buffer must wait the stretched limit
		{mon, wr_ready, low_freq, debug_en} = 4'h3;
		run('{1'b0, 11'h200, 9'h004, 9'h000, 1'b0});
		chk_val("drop_delay", 16'h0001, 16'(dl inside {[LIM-10:LIM+5]}));
		// The last byte's full buffer is drained below, not dropped
		chk_val("drops", 16'h0002, 16'(ld));
		{wc, wr_ready, low_freq, debug_en} = {32'h0, 3'h4};
		repeat (10) @(negedge clk);
		chk_val("drained", 16'h0002, 16'(wc));
		mon = 1'b1;
		// Host frozen after the first byte: the gap drops the sequence
		fork
			run('{1'b0, 11'h010, 9'h001, 9'h000, 1'b0});
			begin
				@(posedge lk.ss_n);
				@(negedge clk);
				hen = 1'b0;
				repeat (3100) @(negedge clk);
				hen = 1'b1;
			end
		join
		repeat (3100) @(negedge clk);
		chk_val("late_writes", 16'h0000, 16'(wc));
		// Sensor end frozen: an idle sleep request must not take effect
		{den, sleep_req} = 2'b01;
		repeat (50) @(negedge clk);
		chk_val("frozen", 16'h0000, 16'(asleep));
		den = 1'b1;
		repeat (50) @(negedge clk);
		chk_val("asleep", 16'h0001, 16'(asleep));
		{sleep_req, wake_req} = 2'b01;
		while (busy !== 1'b1)
			@(negedge clk);
		wake_req = 1'b0;
		repeat (100) @(negedge clk);
		chk_val("awake", 16'h0000, 16'(asleep));
		chk_val("wake_hold", 16'h0000, 16'(lk.ready_level));
		$display("test sleep and wake done");
		run(rows[1]);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
